// file: rtl/cmp_mode_ctrl.sv
// mode, sleep, init and power-down control of the can controller
`timescale 1ns/1ps
`default_nettype none
module cmp_mode_ctrl
    import cmp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire cmp_ctrl_t  ctrl,
    input  wire cmp_cpu_t   cpu_mode,
    input  wire cmp_proto_t proto,
    input  wire logic [2:0] tx_buffer_empty,
    input  wire logic       rx_full_flag,
    input  wire logic       rx_bg_pending,
    input  wire logic       abort_req,
    input  wire logic       busoff,
    input  wire logic       can_rx_pin,
    output logic            can_tx_pin,
    output logic            proto_rx,
    output logic            proto_clk_en,
    output logic            tx_start_allow,
    output logic            ack_ignore,
    output logic            lb_irq_both,
    output logic            fg_copy_en,
    output logic            abort_en,
    output logic            busoff_cnt_en,
    output logic            ctrl_regs_clear,
    output logic            proto_abort,
    output logic            reg_access_en,
    output cmp_stat_t       stat,
    output cmp_mode_t       mode
);
    cmp_mode_t  mode_r;
    cmp_mode_t  mode_nxt;
    logic       rx_s1_r;
    logic       rx_s2_r;
    logic       wakeup_enable_lat_r;
    logic       slept_r;
    logic       wake_irq_r;
    logic [1:0] init_sync_r;
    logic [3:0] idle_cnt_r;
    logic       synced_r;
    logic [7:0] rec_cnt_r;
    logic       activity;
    logic       pd_req;
    logic       tx_pending;
    logic       sleep_ok;

    // two-flop synchroniser for the receive pin
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_s1_r <= CMP_RECESSIVE;
            rx_s2_r <= CMP_RECESSIVE;
        end else if (clk_en) begin
            rx_s1_r <= can_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    cmp_rx_filter #(
        .FILT_CYC (CMP_FILTER_CYC)
    ) u_filt (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .clk_en    (clk_en),
        .arm       ((mode_r == CMP_SLEEP) && wakeup_enable_lat_r),
        .filter_on (ctrl.wakeup_filter_mode),
        .rx_in     (rx_s2_r),
        .activity  (activity)
    );

    assign tx_pending = (tx_buffer_empty != 3'b111);
    // sleep only once tx drained and reception finished at bus idle
    assign sleep_ok   = !tx_pending && !proto.tx_active && !proto.rx_active && proto.bus_idle;

    // power-down mapping of cpu modes
    always_comb begin
        unique case (cpu_mode)
            CMP_CPU_RUN:    pd_req = 1'b0;
            CMP_CPU_WAIT:   pd_req = ctrl.stop_in_wait;
            CMP_CPU_STOP3:  pd_req = !(ctrl.sleep_request && slept_r);
            CMP_CPU_STOP12: pd_req = 1'b1;
        endcase
    end

    // mode transitions
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            CMP_DISABLED: begin
                if (ctrl.module_enable) begin
                    mode_nxt = CMP_INIT;
                end
            end
            CMP_NORMAL: begin
                if (ctrl.init_request && init_sync_r[1]) begin
                    mode_nxt = CMP_INIT;
                end else if (pd_req) begin
                    mode_nxt = CMP_PDOWN;
                end else if (ctrl.sleep_request && sleep_ok) begin
                    mode_nxt = CMP_SLEEP;
                end
            end
            CMP_SLEEP: begin
                if (ctrl.init_request && init_sync_r[1]) begin
                    mode_nxt = CMP_INIT;
                end else if (cpu_mode == CMP_CPU_STOP12 || (cpu_mode == CMP_CPU_WAIT && ctrl.stop_in_wait)) begin
                    mode_nxt = CMP_PDOWN;
                end else if (activity || !ctrl.sleep_request) begin
                    mode_nxt = CMP_NORMAL;
                end
            end
            CMP_INIT: begin
                if (!ctrl.init_request) begin
                    mode_nxt = CMP_NORMAL;
                end
            end
            CMP_PDOWN: begin
                if (!pd_req) begin
                    mode_nxt = slept_r ? CMP_SLEEP : CMP_RECOVER;
                end
            end
            CMP_RECOVER: begin
                if (rec_cnt_r == 8'(CMP_RECOVER_CYC)) begin
                    mode_nxt = CMP_NORMAL;
                end
            end
            default: mode_nxt = CMP_DISABLED;
        endcase
        if (!ctrl.module_enable) begin
            mode_nxt = CMP_DISABLED;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= CMP_DISABLED;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
        end
    end

    // init request handshake across the protocol side
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            init_sync_r <= 2'b00;
        end else if (clk_en) begin
            init_sync_r <= {init_sync_r[0], ctrl.init_request};
        end
    end

    // wake-up enable latched on sleep entry; remembers prior sleep
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wakeup_enable_lat_r <= 1'b0;
            slept_r    <= 1'b0;
        end else if (clk_en) begin
            if (mode_r != CMP_SLEEP && mode_nxt == CMP_SLEEP) begin
                wakeup_enable_lat_r <= ctrl.wakeup_enable;
            end
            if (mode_r == CMP_SLEEP) begin
                slept_r <= 1'b1;
            end else if (mode_r != CMP_PDOWN) begin
                slept_r <= 1'b0;
            end
        end
    end

    // wake-up interrupt, set wins over clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wake_irq_r <= 1'b0;
        end else if (clk_en) begin
            if ((mode_r == CMP_SLEEP || mode_r == CMP_PDOWN) && activity && ctrl.wakeup_irq_enable
                && ctrl.sleep_request) begin
                wake_irq_r <= 1'b1;
            end else if (!ctrl.wakeup_irq_enable || mode_r == CMP_INIT) begin
                wake_irq_r <= 1'b0;
            end
        end
    end

    // eleven recessive bits before resync after wake-up, init or recovery
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_r <= 4'h0;
            synced_r   <= 1'b0;
        end else if (clk_en) begin
            if (mode_r != CMP_NORMAL) begin
                idle_cnt_r <= 4'h0;
                synced_r   <= 1'b0;
            end else if (!synced_r && proto.bit_tick) begin
                if (!rx_s2_r) begin
                    idle_cnt_r <= 4'h0;
                end else if (idle_cnt_r == 4'(CMP_IDLE_BITS - 1)) begin
                    synced_r <= 1'b1;
                end else begin
                    idle_cnt_r <= idle_cnt_r + 4'h1;
                end
            end
        end
    end

    // fixed recovery delay after unprepared power down
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rec_cnt_r <= 8'h00;
        end else if (clk_en) begin
            rec_cnt_r <= (mode_r == CMP_RECOVER) ? rec_cnt_r + 8'h01 : 8'h00;
        end
    end

    logic running;
    assign running = (mode_r == CMP_NORMAL);

    // bus pins and internal receive path
    always_comb begin
        can_tx_pin = CMP_RECESSIVE;
        proto_rx   = rx_s2_r;
        if (!running) begin
            can_tx_pin = CMP_RECESSIVE;
            proto_rx   = CMP_RECESSIVE;
        end else if (ctrl.loopback) begin
            can_tx_pin = CMP_RECESSIVE;
            proto_rx   = proto.tx_dominant ? 1'b0 : 1'b1;
        end else if (ctrl.listen_only) begin
            can_tx_pin = CMP_RECESSIVE;
            proto_rx   = rx_s2_r & ~proto.tx_dominant;
        end else begin
            can_tx_pin = ~proto.tx_dominant;
        end
    end

    assign proto_clk_en    = running && synced_r;
    assign tx_start_allow  = running && synced_r && !ctrl.listen_only;
    assign ack_ignore      = running && ctrl.loopback;
    assign lb_irq_both     = running && ctrl.loopback;
    assign fg_copy_en      = running && rx_bg_pending && !rx_full_flag;
    assign abort_en        = running && abort_req;
    assign busoff_cnt_en   = running && busoff;
    assign ctrl_regs_clear = (mode_r == CMP_INIT);
    assign proto_abort     = (mode_r == CMP_INIT) || (mode_r == CMP_PDOWN);
    assign reg_access_en   = (mode_r != CMP_PDOWN) && (mode_r != CMP_DISABLED);

    assign stat.sleep_ack    = (mode_r == CMP_SLEEP) && ctrl.sleep_request;
    assign stat.init_ack     = (mode_r == CMP_INIT) && ctrl.init_request;
    assign stat.wakeup_irq   = wake_irq_r;
    assign stat.cfg_write_en = stat.init_ack;
    assign stat.proto_run    = proto_clk_en;
    assign stat.bus_synced   = synced_r;
    assign mode              = mode_r;

    AST_TX_RECESSIVE_OFFLINE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode_r != CMP_NORMAL) |-> can_tx_pin) else $error("tx not recessive offline");
    AST_LISTEN_NO_TX: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl.listen_only |-> (can_tx_pin && !tx_start_allow)) else $error("listen-only drove bus");
    AST_LISTEN_LOOP: assert property (@(posedge ref_clk) disable iff (!nrst)
        (running && ctrl.listen_only && !ctrl.loopback && proto.tx_dominant) |-> !proto_rx)
        else $error("dominant not looped back");
    AST_LOOPBACK: assert property (@(posedge ref_clk) disable iff (!nrst)
        (running && ctrl.loopback) |-> (can_tx_pin && proto_rx == !proto.tx_dominant && ack_ignore))
        else $error("loopback path wrong");
    AST_DISABLE_CLK: assert property (@(posedge ref_clk) disable iff (!nrst)
        (clk_en && !ctrl.module_enable) |=> (mode_r == CMP_DISABLED && !proto_clk_en))
        else $error("disabled still clocked");
    AST_WAKE_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(wake_irq_r) |-> $past(ctrl.wakeup_irq_enable && ctrl.sleep_request && wakeup_enable_lat_r))
        else $error("wake irq without enables");
    AST_STOP12_PD: assert property (@(posedge ref_clk) disable iff (!nrst)
        (clk_en && cpu_mode == CMP_CPU_STOP12 && ctrl.module_enable && mode_r == CMP_NORMAL
         && !(ctrl.init_request && init_sync_r[1])) |=> (mode_r == CMP_PDOWN))
        else $error("stop1/2 not power down");
    AST_SLEEP_WAIT_TX: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode_r == CMP_NORMAL && (tx_pending || proto.tx_active || proto.rx_active || !proto.bus_idle))
        |=> (mode_r != CMP_SLEEP))
        else $error("slept with tx pending");
    AST_SLEEP_ACK: assert property (@(posedge ref_clk) disable iff (!nrst)
        stat.sleep_ack |-> (mode_r == CMP_SLEEP && ctrl.sleep_request)) else $error("sleep ack wrong");
    AST_SLEEP_FROZEN: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode_r == CMP_SLEEP) |-> (!busoff_cnt_en && !fg_copy_en && !abort_en && proto_rx))
        else $error("activity in sleep");
    AST_RESYNC: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(synced_r) |-> (idle_cnt_r == 4'(CMP_IDLE_BITS - 1))) else $error("resync too early");
    AST_INIT_ACK: assert property (@(posedge ref_clk) disable iff (!nrst)
        stat.init_ack |-> (ctrl_regs_clear && stat.cfg_write_en && proto_abort))
        else $error("init ack without init");
    AST_PD_ACCESS: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode_r == CMP_PDOWN) |-> (!reg_access_en && can_tx_pin)) else $error("power down access");
    AST_RECOVER: assert property (@(posedge ref_clk) disable iff (!nrst)
        (clk_en && mode_r == CMP_PDOWN && !pd_req && !slept_r && ctrl.module_enable) |=> (mode_r == CMP_RECOVER))
        else $error("no recovery cycle");

    COV_SLEEP: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(stat.sleep_ack));
    COV_WAKE: cover property (@(posedge ref_clk) disable iff (!nrst)
        (mode_r == CMP_SLEEP) ##1 (mode_r == CMP_NORMAL));
    COV_INIT: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(stat.init_ack));
    COV_RECOVER: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(mode_r == CMP_RECOVER));

endmodule : cmp_mode_ctrl
`default_nettype wire

// file: shared/cmp_pkg.sv
// package for the can mode and power control block
package cmp_pkg;

    // controller operating modes
    typedef enum logic [2:0] {
        CMP_NORMAL   = 3'b000,
        CMP_SLEEP    = 3'b001,
        CMP_INIT     = 3'b010,
        CMP_PDOWN    = 3'b011,
        CMP_RECOVER  = 3'b100,
        CMP_DISABLED = 3'b101
    } cmp_mode_t;

    // cpu power modes
    typedef enum logic [1:0] {
        CMP_CPU_RUN   = 2'b00,
        CMP_CPU_WAIT  = 2'b01,
        CMP_CPU_STOP3 = 2'b10,
        CMP_CPU_STOP12 = 2'b11
    } cmp_cpu_t;

    // software control bits
    typedef struct packed {
        logic module_enable;
        logic stop_in_wait;
        logic sleep_request;
        logic wakeup_enable;
        logic wakeup_irq_enable;
        logic wakeup_filter_mode;
        logic init_request;
        logic listen_only;
        logic loopback;
    } cmp_ctrl_t;

    // status seen by software
    typedef struct packed {
        logic sleep_ack;
        logic init_ack;
        logic wakeup_irq;
        logic cfg_write_en;
        logic proto_run;
        logic bus_synced;
    } cmp_stat_t;

    // protocol layer handshake
    typedef struct packed {
        logic tx_active;
        logic rx_active;
        logic bus_idle;
        logic tx_dominant;
        logic bit_tick;
    } cmp_proto_t;

    localparam int unsigned CMP_IDLE_BITS      = 11;
    localparam int unsigned CMP_BUSOFF_RUNS    = 128;
    localparam int unsigned CMP_CLK_MHZ        = 20;
    localparam int unsigned CMP_RECOVER_NS     = 1000;
    localparam int unsigned CMP_RECOVER_CYC    = (CMP_RECOVER_NS * CMP_CLK_MHZ) / 1000;
    localparam int unsigned CMP_FILTER_CYC     = 8;
    localparam int unsigned CMP_INIT_SYNC_CYC  = 3;
    localparam logic        CMP_RECESSIVE      = 1'b1;

endpackage : cmp_pkg

// file: rtl/cmp_rx_filter.sv
// wake-up glitch filter and bus activity detector on the synchronised receive line
`timescale 1ns/1ps
`default_nettype none
module cmp_rx_filter
    import cmp_pkg::*;
#(
    parameter int unsigned FILT_CYC = CMP_FILTER_CYC
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic arm,
    input  wire logic filter_on,
    input  wire logic rx_in,
    output logic      activity
);
    logic [7:0] cnt_r;

    // counts consecutive dominant samples while armed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
        end else if (clk_en) begin
            if (!arm || rx_in) begin
                cnt_r <= 8'h00;
            end else if (cnt_r != 8'hff) begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    // short dominant glitches are ignored with the filter on
    assign activity = arm && (filter_on ? (cnt_r >= 8'(FILT_CYC)) : !rx_in);

endmodule : cmp_rx_filter
`default_nettype wire

// file: verif/cmp_can_node.sv
// behavioural far-side can node: pulled-up bus line and bit timing
`timescale 1ns/1ps
`default_nettype none
module cmp_can_node (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic can_tx_pin,
    output logic      can_rx_pin,
    output logic      bit_tick
);
    logic       dom_r;
    logic [1:0] div_r;

    // wired-and bus with pull-up: recessive unless a node drives dominant
    assign can_rx_pin = can_tx_pin & ~dom_r;
    assign bit_tick   = (div_r == 2'h3);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    initial dom_r = 1'b0;

    // drive a dominant level for n clock cycles
    task automatic dom(input int n);
        @(posedge ref_clk);
        #5 dom_r = 1'b1;
        repeat (n) @(posedge ref_clk);
        #5 dom_r = 1'b0;
    endtask : dom
endmodule : cmp_can_node
`default_nettype wire

// file: verif/can_mode_power_control_tb.sv
// self-checking testbench for the can mode and power control block
`timescale 1ns/1ps
`default_nettype none
module can_mode_power_control_tb;
    import cmp_pkg::*;
    logic       ref_clk, nrst, clk_en, rx_full_flag, rx_bg_pending, abort_req, busoff;
    logic       can_rx_pin, can_tx_pin, bit_tick, proto_rx, proto_clk_en, tx_start_allow;
    logic       ack_ignore, lb_irq_both, fg_copy_en, abort_en, busoff_cnt_en;
    logic       ctrl_regs_clear, proto_abort, reg_access_en;
    logic [3:0] pr;
    logic [2:0] txe;
    cmp_ctrl_t  ctrl;
    cmp_cpu_t   cpu_mode;
    cmp_proto_t proto;
    cmp_stat_t  stat;
    cmp_mode_t  mode;
    int         num_errors, n_compared, i;
    cmp_cpu_t   cm [5] = '{CMP_CPU_RUN, CMP_CPU_WAIT, CMP_CPU_WAIT, CMP_CPU_STOP3, CMP_CPU_STOP12};
    logic       siw [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic       pd [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    // pr holds tx_active, rx_active, bus_idle, tx_dominant
    assign proto = {pr, bit_tick};

    cmp_can_node node (.ref_clk(ref_clk), .nrst(nrst), .can_tx_pin(can_tx_pin), .can_rx_pin(can_rx_pin),
                       .bit_tick(bit_tick));

    cmp_mode_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .ctrl(ctrl), .cpu_mode(cpu_mode),
        .proto(proto), .tx_buffer_empty(txe), .rx_full_flag(rx_full_flag), .rx_bg_pending(rx_bg_pending),
        .abort_req(abort_req), .busoff(busoff), .can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin),
        .proto_rx(proto_rx), .proto_clk_en(proto_clk_en), .tx_start_allow(tx_start_allow),
        .ack_ignore(ack_ignore), .lb_irq_both(lb_irq_both), .fg_copy_en(fg_copy_en), .abort_en(abort_en),
        .busoff_cnt_en(busoff_cnt_en), .ctrl_regs_clear(ctrl_regs_clear), .proto_abort(proto_abort),
        .reg_access_en(reg_access_en), .stat(stat), .mode(mode));

    always #25 ref_clk = ~ref_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask : tick

    task automatic wait_mode(input cmp_mode_t m);
        int k;
        k = 0;
        while (mode !== m && k < 200) begin
            tick(1);
            k++;
        end
        chk(mode, m);
    endtask : wait_mode

    task automatic wait_sync();
        int k;
        k = 0;
        while (stat.bus_synced !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        chk(stat.bus_synced, 1'b1);
    endtask : wait_sync

    task automatic endt(input string s);
        $display("test %s done, errors so far %0d", s, num_errors);
    endtask : endt

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        ref_clk = 0; nrst = 0; clk_en = 1; ctrl = '0; cpu_mode = CMP_CPU_RUN; pr = 4'h2; txe = 3'h7;
        rx_full_flag = 0; rx_bg_pending = 0; abort_req = 0; busoff = 0; num_errors = 0; n_compared = 0;
        ctrl.module_enable = 1;
        ctrl.init_request = 1;
        tick(16);
        chk(can_tx_pin, 1'b1);
        nrst = 1;
        wait_mode(CMP_INIT);
        chk(stat.init_ack, 1'b1);
        chk(stat.cfg_write_en, 1'b1);
        chk(ctrl_regs_clear, 1'b1);
        chk(proto_abort, 1'b1);
        chk(can_tx_pin, 1'b1);
        ctrl.init_request = 0;
        wait_mode(CMP_NORMAL);
        chk(stat.cfg_write_en, 1'b0);
        wait_sync();
        chk(tx_start_allow, 1'b1);
        chk(stat.proto_run, 1'b1);
        endt("init");
        pr[0] = 1;
        tick(1);
        chk(can_tx_pin, 1'b0);
        ctrl.listen_only = 1;
        tick(1);
        chk(can_tx_pin, 1'b1);
        chk(tx_start_allow, 1'b0);
        chk(proto_rx, 1'b0);
        ctrl.listen_only = 0;
        ctrl.loopback = 1;
        tick(1);
        chk(can_tx_pin, 1'b1);
        chk(proto_rx, 1'b0);
        chk(ack_ignore, 1'b1);
        chk(lb_irq_both, 1'b1);
        pr[0] = 0;
        fork
            node.dom(8);
            begin
                tick(5);
                chk(proto_rx, 1'b1);
            end
        join
        ctrl.loopback = 0;
        endt("test modes");
        txe = 3'h5;
        busoff = 1;
        tick(2);
        ctrl.sleep_request = 1;
        tick(10);
        chk(mode, CMP_NORMAL);
        chk(stat.sleep_ack, 1'b0);
        txe = 3'h7;
        pr = 4'ha;
        tick(4);
        chk(mode, CMP_NORMAL);
        pr = 4'h4;
        tick(4);
        chk(mode, CMP_NORMAL);
        pr = 4'h2;
        wait_mode(CMP_SLEEP);
        chk(stat.sleep_ack, 1'b1);
        chk(proto_clk_en, 1'b0);
        chk(stat.proto_run, 1'b0);
        chk(reg_access_en, 1'b1);
        chk(busoff_cnt_en, 1'b0);
        chk(can_tx_pin, 1'b1);
        rx_bg_pending = 1;
        abort_req = 1;
        tick(1);
        chk(fg_copy_en, 1'b0);
        chk(abort_en, 1'b0);
        fork
            node.dom(40);
            begin
                tick(10);
                chk(proto_rx, 1'b1);
            end
        join
        tick(4);
        chk(mode, CMP_SLEEP);
        ctrl.wakeup_enable = 1;
        node.dom(40);
        tick(4);
        chk(mode, CMP_SLEEP);
        ctrl.sleep_request = 0;
        wait_mode(CMP_NORMAL);
        chk(stat.bus_synced, 1'b0);
        tick(30);
        chk(stat.bus_synced, 1'b0);
        wait_sync();
        chk(fg_copy_en, 1'b1);
        chk(abort_en, 1'b1);
        chk(busoff_cnt_en, 1'b1);
        rx_bg_pending = 0;
        abort_req = 0;
        busoff = 0;
        endt("sleep");
        ctrl.wakeup_irq_enable = 1;
        ctrl.wakeup_filter_mode = 1;
        ctrl.sleep_request = 1;
        wait_mode(CMP_SLEEP);
        node.dom(4);
        tick(10);
        chk(mode, CMP_SLEEP);
        chk(stat.wakeup_irq, 1'b0);
        fork
            node.dom(20);
        join_none
        wait_mode(CMP_NORMAL);
        ctrl.sleep_request = 0;
        chk(stat.wakeup_irq, 1'b1);
        ctrl.wakeup_irq_enable = 0;
        tick(2);
        chk(stat.wakeup_irq, 1'b0);
        wait_sync();
        endt("wake-up");
        for (i = 0; i < 5; i++) begin
            ctrl.stop_in_wait = siw[i];
            cpu_mode = cm[i];
            tick(3);
            chk(mode, pd[i] ? CMP_PDOWN : CMP_NORMAL);
            if (pd[i]) begin
                chk(can_tx_pin, 1'b1);
                chk(reg_access_en, 1'b0);
                chk(proto_clk_en, 1'b0);
                chk(proto_abort, 1'b1);
                cpu_mode = CMP_CPU_RUN;
                tick(2);
                chk(mode, CMP_RECOVER);
                tick(CMP_RECOVER_CYC - 1);
                chk(mode, CMP_RECOVER);
                tick(1);
                chk(mode, CMP_NORMAL);
            end
            cpu_mode = CMP_CPU_RUN;
            ctrl.stop_in_wait = 0;
            tick(1);
        end
        ctrl.sleep_request = 1;
        wait_mode(CMP_SLEEP);
        cpu_mode = CMP_CPU_STOP3;
        tick(3);
        chk(mode, CMP_SLEEP);
        cpu_mode = CMP_CPU_STOP12;
        tick(3);
        chk(mode, CMP_PDOWN);
        cpu_mode = CMP_CPU_RUN;
        wait_mode(CMP_SLEEP);
        endt("power");
        ctrl.init_request = 1;
        tick(2);
        chk(mode, CMP_SLEEP);
        wait_mode(CMP_INIT);
        ctrl.sleep_request = 0;
        ctrl.init_request = 0;
        wait_mode(CMP_NORMAL);
        ctrl.init_request = 1;
        tick(1);
        ctrl.init_request = 0;
        tick(6);
        chk(mode, CMP_NORMAL);
        chk(stat.init_ack, 1'b0);
        clk_en = 0;
        ctrl.module_enable = 0;
        tick(3);
        chk(mode, CMP_NORMAL);
        clk_en = 1;
        tick(2);
        chk(mode, CMP_DISABLED);
        chk(proto_clk_en, 1'b0);
        endt("init and disable");
        wrap_up();
    end
endmodule : can_mode_power_control_tb
`default_nettype wire
